// ==== psf_pkg.sv ====
package psf_pkg;
    // Special-function address and bit positions of the status byte
    localparam logic [7:0] PSF_STATUS_ADDR = 8'hd0;
    localparam int PSF_BIT_CARRY  = 7;
    localparam int PSF_BIT_HALF   = 6;
    localparam int PSF_BIT_USER0  = 5;
    localparam int PSF_BIT_BANK_H = 4;
    localparam int PSF_BIT_BANK_L = 3;
    localparam int PSF_BIT_OVF    = 2;
    localparam int PSF_BIT_USER1  = 1;
    localparam int PSF_BIT_PARITY = 0;
    localparam logic [7:0] PSF_STATUS_RESET = 8'h00;
    localparam logic [7:0] PSF_BANK_STRIDE  = 8'h08;

    // Space selected by instruction type
    typedef enum logic [1:0]
    {
        PSF_SPACE_CODE,
        PSF_SPACE_DATA_DIRECT,
        PSF_SPACE_DATA_INDIRECT,
        PSF_SPACE_SFR
    } psf_space_t;

    // Arithmetic operation kind reported by the ALU
    typedef enum logic [2:0]
    {
        PSF_OP_NONE,
        PSF_OP_ADD,
        PSF_OP_SUB,
        PSF_OP_MUL,
        PSF_OP_DIV,
        PSF_OP_OTHER
    } psf_op_t;

    typedef struct packed
    {
        logic       valid;
        psf_op_t    op;
        logic [7:0] lhs;
        logic [7:0] rhs;
        logic       carry_in;
    } psf_alu_req_t;

    typedef struct packed
    {
        logic       wr;
        logic       bit_op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } psf_sfr_req_t;
endpackage

// ==== psf_flag_calc.sv ====
`timescale 1ns/1ps
module psf_flag_calc
(
    // Operation
    input  wire psf_pkg::psf_alu_req_t req,
    // Flag results
    output logic                       upd_carry,
    output logic                       upd_half,
    output logic                       upd_ovf,
    output logic                       carry_val,
    output logic                       half_val,
    output logic                       ovf_val
);
    import psf_pkg::*;

    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [8:0]  dif9;
    logic [4:0]  dif5;
    logic [15:0] prod;
    logic [7:0]  res;

    always_comb
    begin
        sum9 = {1'b0, req.lhs} + {1'b0, req.rhs} + {8'h00, req.carry_in};
        sum5 = {1'b0, req.lhs[3:0]} + {1'b0, req.rhs[3:0]} + {4'h0, req.carry_in};
        dif9 = {1'b0, req.lhs} - {1'b0, req.rhs} - {8'h00, req.carry_in};
        dif5 = {1'b0, req.lhs[3:0]} - {1'b0, req.rhs[3:0]} - {4'h0, req.carry_in};
        prod = {8'h00, req.lhs} * {8'h00, req.rhs};
        res = 8'h00;
        upd_carry = 1'b0;
        upd_half = 1'b0;
        upd_ovf = 1'b0;
        carry_val = 1'b0;
        half_val = 1'b0;
        ovf_val = 1'b0;
        if (req.valid)
        begin
            case (req.op)
                PSF_OP_ADD:
                begin
                    res = sum9[7:0];
                    upd_carry = 1'b1;
                    carry_val = sum9[8];
                    upd_half = 1'b1;
                    half_val = sum5[4];
                    upd_ovf = 1'b1;
                    ovf_val = (req.lhs[7] == req.rhs[7]) && (res[7] != req.lhs[7]);
                end
                PSF_OP_SUB:
                begin
                    res = dif9[7:0];
                    upd_carry = 1'b1;
                    carry_val = dif9[8];
                    upd_half = 1'b1;
                    half_val = dif5[4];
                    upd_ovf = 1'b1;
                    ovf_val = (req.lhs[7] != req.rhs[7]) && (res[7] != req.lhs[7]);
                end
                PSF_OP_MUL:
                begin
                    upd_carry = 1'b1;
                    upd_half = 1'b1;
                    upd_ovf = 1'b1;
                    ovf_val = (prod[15:8] != 8'h00);
                end
                PSF_OP_DIV:
                begin
                    upd_carry = 1'b1;
                    upd_half = 1'b1;
                    upd_ovf = 1'b1;
                    ovf_val = (req.rhs == 8'h00);
                end
                PSF_OP_OTHER:
                begin
                    // Other arithmetic clears the half carry
                    upd_half = 1'b1;
                end
                default:
                begin
                    res = 8'h00;
                end
            endcase
        end
    end
endmodule

// ==== psf_status_flags.sv ====
`timescale 1ns/1ps
module psf_status_flags
(
    // Clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  RSTN,
    // Arithmetic unit
    input  wire psf_pkg::psf_alu_req_t ALU_REQ,
    input  wire logic [7:0]            ACC_VALUE,
    // Special-function access
    input  wire psf_pkg::psf_sfr_req_t SFR_REQ,
    output logic [7:0]                 SFR_RDATA,
    output logic                       SFR_HIT,
    // Instruction addressing
    input  wire logic                  IS_CODE_FETCH,
    input  wire logic                  IS_INDIRECT,
    input  wire logic [2:0]            REG_INDEX,
    // Status outputs
    output logic [7:0]                 STATUS_WORD,
    output logic [7:0]                 REG_ADDR,
    output logic [7:0]                 PTR0_ADDR,
    output logic [7:0]                 PTR1_ADDR,
    output psf_pkg::psf_space_t        ACCESS_SPACE
);
    import psf_pkg::*;

    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       hit_reg;
    logic       hit_next;
    logic [7:0] reg_addr_reg;
    logic [7:0] reg_addr_next;
    logic [7:0] ptr0_reg;
    logic [7:0] ptr0_next;
    logic [7:0] ptr1_reg;
    logic [7:0] ptr1_next;
    psf_space_t space_reg;
    psf_space_t space_next;
    logic       upd_carry;
    logic       upd_half;
    logic       upd_ovf;
    logic       carry_val;
    logic       half_val;
    logic       ovf_val;
    logic       sel;
    logic [7:0] bank_base;
    logic [7:0] sw_mask;

    psf_flag_calc u_calc
    (
        .req       (ALU_REQ),
        .upd_carry (upd_carry),
        .upd_half  (upd_half),
        .upd_ovf   (upd_ovf),
        .carry_val (carry_val),
        .half_val  (half_val),
        .ovf_val   (ovf_val)
    );

    always_comb
    begin
        sel = (SFR_REQ.addr == PSF_STATUS_ADDR);
        sw_mask = 8'h00;
        if (sel && SFR_REQ.wr)
        begin
            if (SFR_REQ.bit_op)
            begin
                sw_mask = 8'h01 << SFR_REQ.bit_sel;
            end
            else
            begin
                sw_mask = 8'hff;
            end
        end
        // Parity is never stored from software
        sw_mask[PSF_BIT_PARITY] = 1'b0;
        status_next = (status_reg & ~sw_mask) | (SFR_REQ.wdata & sw_mask);
        if (SFR_REQ.bit_op)
        begin
            status_next = (status_reg & ~sw_mask) | ({8{SFR_REQ.wdata[0]}} & sw_mask);
        end
        // Hardware flag updates win over a same-cycle software write
        if (upd_carry)
        begin
            status_next[PSF_BIT_CARRY] = carry_val;
        end
        if (upd_half)
        begin
            status_next[PSF_BIT_HALF] = half_val;
        end
        if (upd_ovf)
        begin
            status_next[PSF_BIT_OVF] = ovf_val;
        end
        status_next[PSF_BIT_PARITY] = ^ACC_VALUE;
        rdata_next = sel ? status_next : 8'h00;
        hit_next = sel;
        bank_base = PSF_BANK_STRIDE
            * {6'h00, status_next[PSF_BIT_BANK_H:PSF_BIT_BANK_L]};
        reg_addr_next = bank_base | {5'h00, REG_INDEX};
        ptr0_next = bank_base;
        ptr1_next = bank_base | 8'h01;
        if (IS_CODE_FETCH)
        begin
            space_next = PSF_SPACE_CODE;
        end
        else if (IS_INDIRECT)
        begin
            space_next = PSF_SPACE_DATA_INDIRECT;
        end
        else if (SFR_REQ.addr[7])
        begin
            space_next = PSF_SPACE_SFR;
        end
        else
        begin
            space_next = PSF_SPACE_DATA_DIRECT;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            status_reg <= PSF_STATUS_RESET;
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
            reg_addr_reg <= 8'h00;
            ptr0_reg <= 8'h00;
            ptr1_reg <= 8'h01;
            space_reg <= PSF_SPACE_CODE;
        end
        else
        begin
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
            reg_addr_reg <= reg_addr_next;
            ptr0_reg <= ptr0_next;
            ptr1_reg <= ptr1_next;
            space_reg <= space_next;
        end
    end

    assign STATUS_WORD = status_reg;
    assign SFR_RDATA = rdata_reg;
    assign SFR_HIT = hit_reg;
    assign REG_ADDR = reg_addr_reg;
    assign PTR0_ADDR = ptr0_reg;
    assign PTR1_ADDR = ptr1_reg;
    assign ACCESS_SPACE = space_reg;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_add_signed_ovf;
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_ADD && ALU_REQ.lhs[7] == ALU_REQ.rhs[7]
            && (ALU_REQ.lhs[7] != ((ALU_REQ.lhs + ALU_REQ.rhs + {7'h00, ALU_REQ.carry_in}) >> 7));
    endsequence

    a_status_byte_read: assert property (
        SFR_REQ.addr == PSF_STATUS_ADDR |=> SFR_HIT && SFR_RDATA == STATUS_WORD)
        else $error("status byte read mismatch");
    a_half_carry_add: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_ADD
        |=> STATUS_WORD[PSF_BIT_HALF] ==
            $past(({1'b0, ALU_REQ.lhs[3:0]} + {1'b0, ALU_REQ.rhs[3:0]}
                 + {4'h0, ALU_REQ.carry_in}) > 5'h0f))
        else $error("half carry wrong after add");
    a_bank_pointer: assert property (
        ##1 PTR0_ADDR == {3'h0, STATUS_WORD[4:3], 3'h0})
        else $error("bank pointer does not follow bank field");
    a_ovf_add_set: assert property (
        s_add_signed_ovf |=> STATUS_WORD[PSF_BIT_OVF])
        else $error("signed overflow not flagged");
    a_ovf_mul: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_MUL
        |=> STATUS_WORD[PSF_BIT_OVF] == ($past(ALU_REQ.lhs) * $past(ALU_REQ.rhs) > 16'h00ff))
        else $error("multiply overflow wrong");
    a_ovf_div_zero: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_DIV && ALU_REQ.rhs == 8'h00
        |=> STATUS_WORD[PSF_BIT_OVF])
        else $error("divide by zero not flagged");
    a_ovf_div_clear: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_DIV && ALU_REQ.rhs != 8'h00
        |=> !STATUS_WORD[PSF_BIT_OVF])
        else $error("divide did not clear overflow");
    a_parity_follow: assert property (
        1'b1 |=> STATUS_WORD[PSF_BIT_PARITY] == $past(^ACC_VALUE))
        else $error("parity does not follow accumulator");
    a_code_space: assert property (
        IS_CODE_FETCH |=> ACCESS_SPACE == PSF_SPACE_CODE)
        else $error("code fetch not routed to program space");
    a_second_pointer: assert property (
        ##1 PTR1_ADDR == (PTR0_ADDR | 8'h01))
        else $error("second pointer register misplaced");
    a_carry_add: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_ADD
        |=> STATUS_WORD[PSF_BIT_CARRY] ==
            $past(({1'b0, ALU_REQ.lhs} + {1'b0, ALU_REQ.rhs}
                 + {8'h00, ALU_REQ.carry_in}) > 9'h0ff))
        else $error("carry wrong after add");
    a_half_other_clear: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_OTHER |=> !STATUS_WORD[PSF_BIT_HALF])
        else $error("half carry not cleared by other arithmetic");
    a_ovf_sub_set: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_SUB && ALU_REQ.lhs[7] != ALU_REQ.rhs[7]
            && ALU_REQ.lhs[7] != 1'((ALU_REQ.lhs - ALU_REQ.rhs - {7'h00, ALU_REQ.carry_in}) >> 7)
        |=> STATUS_WORD[PSF_BIT_OVF])
        else $error("signed overflow on subtract not flagged");
    a_ovf_add_clear: assert property (
        ALU_REQ.valid && ALU_REQ.op == PSF_OP_ADD && ALU_REQ.lhs[7] != ALU_REQ.rhs[7]
        |=> !STATUS_WORD[PSF_BIT_OVF])
        else $error("add with mixed signs did not clear overflow");
    a_fourth_bank: assert property (
        STATUS_WORD[PSF_BIT_BANK_H:PSF_BIT_BANK_L] == 2'b11 |-> REG_ADDR[7:3] == 5'h03)
        else $error("fourth bank not mapped to its registers");
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import psf_pkg::*;

    logic         sys_clk;
    logic         rst_n;
    psf_alu_req_t alu_req;
    logic [7:0]   acc_value;
    psf_sfr_req_t sfr_req;
    logic [7:0]   sfr_rdata;
    logic         sfr_hit;
    logic         is_code_fetch;
    logic         is_indirect;
    logic [2:0]   reg_index;
    logic [7:0]   status_word;
    logic [7:0]   reg_addr;
    logic [7:0]   ptr0_addr;
    logic [7:0]   ptr1_addr;
    psf_space_t   access_space;
    int           err_total = 0;
    int           checked = 0;

    psf_status_flags psf_status_flags_inst
    (
        .SYS_CLK       (sys_clk),
        .RSTN          (rst_n),
        .ALU_REQ       (alu_req),
        .ACC_VALUE     (acc_value),
        .SFR_REQ       (sfr_req),
        .SFR_RDATA     (sfr_rdata),
        .SFR_HIT       (sfr_hit),
        .IS_CODE_FETCH (is_code_fetch),
        .IS_INDIRECT   (is_indirect),
        .REG_INDEX     (reg_index),
        .STATUS_WORD   (status_word),
        .REG_ADDR      (reg_addr),
        .PTR0_ADDR     (ptr0_addr),
        .PTR1_ADDR     (ptr1_addr),
        .ACCESS_SPACE  (access_space)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One idle cycle before each request keeps every input to one change per step
    task automatic drive(input psf_alu_req_t a, input psf_sfr_req_t s);
        @(negedge sys_clk);
        alu_req = a;
        sfr_req = s;
        @(negedge sys_clk);
        alu_req = '0;
        sfr_req = '0;
    endtask

    task automatic arith(input psf_op_t op, input logic [7:0] l, input logic [7:0] r,
                         input logic ci, input logic [7:0] exp);
        drive('{1'b1, op, l, r, ci}, '0);
        check("status after arithmetic", status_word, exp);
    endtask

    task automatic sfr_wr(input logic bit_op, input logic [2:0] sel, input logic [7:0] d);
        drive('0, '{1'b1, bit_op, PSF_STATUS_ADDR, sel, d});
    endtask

    task automatic test_arith();
        arith(PSF_OP_ADD, 8'h7e, 8'h01, 1'b1, 8'h44);
        arith(PSF_OP_OTHER, 8'h00, 8'h00, 1'b0, 8'h04);
        arith(PSF_OP_ADD, 8'hff, 8'h01, 1'b0, 8'hc0);
        arith(PSF_OP_SUB, 8'h80, 8'h01, 1'b0, 8'h44);
        arith(PSF_OP_SUB, 8'h00, 8'h01, 1'b0, 8'hc0);
        arith(PSF_OP_SUB, 8'h10, 8'h0f, 1'b1, 8'h40);
        // Overflow must be set first so that the add below really clears it
        arith(PSF_OP_DIV, 8'h08, 8'h00, 1'b0, 8'h04);
        arith(PSF_OP_ADD, 8'h01, 8'h02, 1'b0, 8'h00);
        arith(PSF_OP_MUL, 8'h10, 8'h10, 1'b0, 8'h04);
        arith(PSF_OP_MUL, 8'h0f, 8'h11, 1'b0, 8'h00);
        arith(PSF_OP_DIV, 8'h08, 8'h00, 1'b0, 8'h04);
        arith(PSF_OP_DIV, 8'h08, 8'h02, 1'b0, 8'h00);
        // Hardware carry and half carry must win over a same-cycle byte write
        drive('{1'b1, PSF_OP_ADD, 8'hff, 8'h01, 1'b0},
              '{1'b1, 1'b0, PSF_STATUS_ADDR, 3'd0, 8'h20});
        check("write collision", status_word, 8'he0);
        sfr_wr(1'b0, 3'd0, 8'h00);
    endtask

    task automatic test_bits();
        for (int i = 1; i < 8; i++)
        begin
            sfr_wr(1'b1, i[2:0], 8'h01);
            check("bit set", status_word, 8'h01 << i);
            sfr_wr(1'b1, i[2:0], 8'h00);
            check("bit clear", status_word, 8'h00);
        end
        sfr_wr(1'b1, 3'd0, 8'h01);
        check("parity bit write", status_word, 8'h00);
        sfr_wr(1'b0, 3'd0, 8'hff);
        drive('0, '{1'b0, 1'b0, PSF_STATUS_ADDR, 3'd0, 8'h00});
        check("read hit", {7'h00, sfr_hit}, 8'h01);
        check("read data", sfr_rdata, 8'hfe);
        drive('0, '{1'b1, 1'b0, 8'hd1, 3'd0, 8'h00});
        check("other address hit", {7'h00, sfr_hit}, 8'h00);
        check("other address data", sfr_rdata, 8'h00);
        check("other address write", status_word, 8'hfe);
        sfr_wr(1'b0, 3'd0, 8'h00);
    endtask

    task automatic test_banks();
        reg_index = 3'd5;
        for (int b = 0; b < 4; b++)
        begin
            sfr_wr(1'b0, 3'd0, 8'(b << 3));
            check("pointer zero", ptr0_addr, 8'(b * 8));
            check("pointer one", ptr1_addr, 8'(b * 8 + 1));
            check("register address", reg_addr, 8'(b * 8 + 5));
        end
        check("fourth bank base", ptr0_addr, 8'h18);
        sfr_wr(1'b0, 3'd0, 8'h00);
    endtask

    task automatic test_parity();
        logic [7:0] vals [6] = '{8'h01, 8'h03, 8'h80, 8'hff, 8'h7f, 8'h00};
        foreach (vals[i])
        begin
            acc_value = vals[i];
            drive('0, '0);
            check("parity", {7'h00, status_word[0]}, {7'h00, ^vals[i]});
        end
    endtask

    task automatic test_space();
        logic [2:0] cfg [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
        psf_space_t exp [4] = '{PSF_SPACE_CODE, PSF_SPACE_DATA_INDIRECT, PSF_SPACE_SFR,
                                PSF_SPACE_DATA_DIRECT};
        for (int i = 0; i < 4; i++)
        begin
            is_code_fetch = cfg[i][2];
            is_indirect = cfg[i][1];
            drive('0, '{1'b0, 1'b0, {cfg[i][0], 7'h10}, 3'd0, 8'h00});
            check("access space", {6'h00, access_space}, {6'h00, exp[i]});
        end
        is_code_fetch = 1'b0;
        is_indirect = 1'b0;
    endtask

    initial
    begin
        rst_n = 1'b0;
        alu_req = '0;
        sfr_req = '0;
        acc_value = 8'h00;
        is_code_fetch = 1'b0;
        is_indirect = 1'b0;
        reg_index = 3'd0;
        repeat (10) @(negedge sys_clk);
        check("reset status", status_word, PSF_STATUS_RESET);
        check("reset pointer one", ptr1_addr, 8'h01);
        rst_n = 1'b1;
        test_arith();
        test_bits();
        test_banks();
        test_parity();
        test_space();
        complete_run();
    end

    // The whole sequence needs about a hundred cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule
